// ### logic/spl_cfg.svh
// Constants of the sector protection host controller: timing, bus cycles and command codes
`ifndef SPL_CFG_SVH
`define SPL_CFG_SVH

// Clock period and timing figures
`define SPL_CLK_NS 4
`define SPL_SETUP_NS 20
`define SPL_WE_NS 35
`define SPL_HOLD_NS 20
`define SPL_READ_NS 100
`define SPL_BUSY_NS 100
`define SPL_TRP_NS 500
`define SPL_TIMEOUT_US 2000
`define SPL_SETUP_CYC ((`SPL_SETUP_NS + `SPL_CLK_NS - 1) / `SPL_CLK_NS)
`define SPL_WE_CYC ((`SPL_WE_NS + `SPL_CLK_NS - 1) / `SPL_CLK_NS)
`define SPL_HOLD_CYC ((`SPL_HOLD_NS + `SPL_CLK_NS - 1) / `SPL_CLK_NS)
`define SPL_READ_CYC ((`SPL_READ_NS + `SPL_CLK_NS - 1) / `SPL_CLK_NS)
`define SPL_BUSY_CYC ((`SPL_BUSY_NS + `SPL_CLK_NS - 1) / `SPL_CLK_NS)
`define SPL_TRP_CYC ((`SPL_TRP_NS + `SPL_CLK_NS - 1) / `SPL_CLK_NS)
`define SPL_TIMEOUT_CYC ((`SPL_TIMEOUT_US * 1000) / `SPL_CLK_NS)

// Mode-select register field positions
`define SPL_PW_SEL_BIT 2
`define SPL_PERS_SEL_BIT 1
`define SPL_SECURED_BIT 0

// Sequence step indices
`define SPL_STEP_ENTRY 3'h2
`define SPL_STEP_OP2 3'h4
`define SPL_STEP_EXIT1 3'h5
`define SPL_STEP_LAST 3'h6

// Unlock cycle addresses and data
`define SPL_UNLOCK_A1 26'h0000555
`define SPL_UNLOCK_A2 26'h00002AA
`define SPL_UNLOCK_D1 16'h00AA
`define SPL_UNLOCK_D2 16'h0055

// Entry, operation and exit codes
`define SPL_ENTRY_MODESEL 16'h0040
`define SPL_ENTRY_PERSIST 16'h00C0
`define SPL_ENTRY_VOLATILE 16'h00E0
`define SPL_ENTRY_FREEZE 16'h0050
`define SPL_OP_PROGRAM 16'h00A0
`define SPL_OP_ERASE 16'h0080
`define SPL_OP_ERASE_ALL 16'h0030
`define SPL_OP_ZERO 16'h0000
`define SPL_OP_ONE 16'h0001
`define SPL_EXIT1 16'h0090
`define SPL_EXIT2 16'h0000

`endif

// ### logic/spl_pkg.sv
// Types of the sector protection host controller
package spl_pkg;

  // Orders taken at the user port
  typedef enum logic [2:0] {
    SPL_CMD_MODESEL_PROG = 3'h0,
    SPL_CMD_PERSIST_PROG = 3'h1,
    SPL_CMD_PERSIST_ERASE = 3'h2,
    SPL_CMD_VOLATILE_SET = 3'h3,
    SPL_CMD_VOLATILE_CLR = 3'h4,
    SPL_CMD_FREEZE_SET = 3'h5,
    SPL_CMD_PERSIST_READ = 3'h6,
    SPL_CMD_HW_RESET = 3'h7
  } spl_cmd_t;

  // Controller states, one-hot
  typedef enum logic [7:0] {
    SPL_IDLE = 8'h01,
    SPL_SETUP = 8'h02,
    SPL_PULSE = 8'h04,
    SPL_HOLD = 8'h08,
    SPL_READ = 8'h10,
    SPL_BUSY = 8'h20,
    SPL_RST = 8'h40,
    SPL_DONE = 8'h80
  } spl_state_t;

endpackage

// ### logic/spl_host.sv
// Host controller driving the flash sector protection command sequences
// Summary of operation
// - Host programs password before password select bit
// - Host sends sector address with program command
// - Host issues exit; device resumes read mode
// - Host freezes only after persistent bits final
`timescale 1ns/1ps
`include "spl_cfg.svh"

module spl_host
  import spl_pkg::*;
#(
  parameter int TIMEOUT_CYC = `SPL_TIMEOUT_CYC
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic cmd_valid_in,
  input wire logic [2:0] cmd_in,
  input wire logic [9:0] sector_in,
  input wire logic [15:0] wdata_in,
  input wire logic password_set_in,
  input wire logic config_final_in,
  input wire logic ready_in,
  input wire logic [15:0] dq_in,
  output logic [25:0] addr_out,
  output logic [15:0] dq_out,
  output logic dq_oe_out,
  output logic ce_n_out,
  output logic we_n_out,
  output logic oe_n_out,
  output logic reset_n_out,
  output logic busy_out,
  output logic done_out,
  output logic error_out,
  output logic [15:0] status_out
);

  spl_state_t state;
  spl_cmd_t cmd_q;
  logic [9:0] sector_q;
  logic [15:0] wdata_q;
  logic [2:0] idx;
  logic [19:0] timer;
  logic [19:0] waited;
  logic err_q;
  logic scheme_locked;
  logic frozen;
  logic [2:0] rdy_sync;
  logic rdy;
  logic [15:0] dq_s1;
  logic [15:0] dq_s2;
  logic [15:0] dq_s3;
  logic refused;
  logic [41:0] step;

  ////////////////////////////////////////////////////////////////////////
  // Bus word for one step of a command sequence: {address, data}
  function automatic logic [41:0] step_word(input spl_cmd_t c, input logic [2:0] i,
                                            input logic [9:0] sa, input logic [15:0] wd);
    logic [25:0] sad;
    logic [15:0] entry;
    logic [41:0] w;
    sad = {sa, 16'h0000}; // Sector address in bits 25..16
    entry = `SPL_ENTRY_PERSIST;
    w = {26'h0000000, `SPL_EXIT2};
    unique case (c)
      SPL_CMD_MODESEL_PROG: entry = `SPL_ENTRY_MODESEL;
      SPL_CMD_VOLATILE_SET, SPL_CMD_VOLATILE_CLR: entry = `SPL_ENTRY_VOLATILE;
      SPL_CMD_FREEZE_SET: entry = `SPL_ENTRY_FREEZE;
      default: entry = `SPL_ENTRY_PERSIST;
    endcase
    unique case (i)
      3'h0: w = {`SPL_UNLOCK_A1, `SPL_UNLOCK_D1};
      3'h1: w = {`SPL_UNLOCK_A2, `SPL_UNLOCK_D2};
      3'h2: w = {`SPL_UNLOCK_A1, entry};
      3'h3: begin
        if (c == SPL_CMD_PERSIST_ERASE) begin
          w = {26'h0000000, `SPL_OP_ERASE}; // No sector address needed
        end else begin
          w = {sad, `SPL_OP_PROGRAM};
        end
      end
      3'h4: begin
        unique case (c)
          SPL_CMD_MODESEL_PROG: w = {26'h0000000, wd};
          SPL_CMD_PERSIST_ERASE: w = {26'h0000000, `SPL_OP_ERASE_ALL};
          SPL_CMD_VOLATILE_CLR: w = {sad, `SPL_OP_ONE}; // One is unprotected
          default: w = {sad, `SPL_OP_ZERO}; // Zero is protected
        endcase
      end
      3'h5: w = {26'h0000000, `SPL_EXIT1}; // Exit restores read mode
      default: w = {26'h0000000, `SPL_EXIT2};
    endcase
    return w;
  endfunction

  assign step = step_word(cmd_q, idx, sector_q, wdata_q);

  ////////////////////////////////////////////////////////////////////////
  // Orders the host must not send
  always_comb begin
    refused = 1'b0;
    if (spl_cmd_t'(cmd_in) == SPL_CMD_MODESEL_PROG) begin
      if (wdata_in[`SPL_PW_SEL_BIT:`SPL_PERS_SEL_BIT] == 2'b00) begin
        refused = 1'b1; // Both selects at once would abort
      end
      if (!wdata_in[`SPL_PW_SEL_BIT] && !password_set_in) begin
        refused = 1'b1; // Password first
      end
      if (scheme_locked && wdata_in[`SPL_PW_SEL_BIT:`SPL_PERS_SEL_BIT] != 2'b11) begin
        refused = 1'b1; // Scheme already fixed
      end
    end
    if (spl_cmd_t'(cmd_in) == SPL_CMD_FREEZE_SET && !config_final_in) begin
      refused = 1'b1;
    end
    if ((spl_cmd_t'(cmd_in) == SPL_CMD_PERSIST_PROG ||
         spl_cmd_t'(cmd_in) == SPL_CMD_PERSIST_ERASE) && frozen) begin
      refused = 1'b1; // Would only time out
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Three-stage synchronisers for ready and data pins
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdy_sync <= 3'h0;
      rdy <= 1'b0;
      dq_s1 <= 16'h0000;
      dq_s2 <= 16'h0000;
      dq_s3 <= 16'h0000;
    end else begin
      rdy_sync <= {rdy_sync[1:0], ready_in};
      if (rdy_sync[2] == rdy_sync[1]) begin
        rdy <= rdy_sync[2];
      end
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Host view of scheme and freeze latch
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      scheme_locked <= 1'b0;
      frozen <= 1'b0;
    end else if (state == SPL_DONE && !err_q) begin
      if (cmd_q == SPL_CMD_MODESEL_PROG &&
          wdata_q[`SPL_PW_SEL_BIT:`SPL_PERS_SEL_BIT] != 2'b11) begin
        scheme_locked <= 1'b1;
      end
      if (cmd_q == SPL_CMD_FREEZE_SET) begin
        frozen <= 1'b1;
      end
      if (cmd_q == SPL_CMD_HW_RESET) begin
        frozen <= 1'b0; // Hardware reset order releases; rst_in clears it too
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer and pin drive
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= SPL_IDLE;
      cmd_q <= SPL_CMD_MODESEL_PROG;
      sector_q <= 10'h000;
      wdata_q <= 16'h0000;
      idx <= 3'h0;
      timer <= 20'h00000;
      waited <= 20'h00000;
      err_q <= 1'b0;
      addr_out <= 26'h0000000;
      dq_out <= 16'h0000;
      dq_oe_out <= 1'b0;
      ce_n_out <= 1'b1;
      we_n_out <= 1'b1;
      oe_n_out <= 1'b1;
      reset_n_out <= 1'b1;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      error_out <= 1'b0;
      status_out <= 16'h0000;
    end else begin
      done_out <= 1'b0;
      if (timer != 20'h00000) begin
        timer <= timer - 20'h00001;
      end
      unique case (state)
        SPL_IDLE: begin
          if (cmd_valid_in) begin
            cmd_q <= spl_cmd_t'(cmd_in);
            sector_q <= sector_in;
            wdata_q <= wdata_in;
            idx <= 3'h0;
            err_q <= refused;
            busy_out <= 1'b1;
            if (refused) begin
              state <= SPL_DONE;
            end else if (spl_cmd_t'(cmd_in) == SPL_CMD_HW_RESET) begin
              reset_n_out <= 1'b0;
              timer <= 20'(`SPL_TRP_CYC - 1);
              state <= SPL_RST;
            end else begin
              timer <= 20'(`SPL_SETUP_CYC - 1);
              state <= SPL_SETUP;
            end
          end
        end
        SPL_SETUP: begin
          addr_out <= step[41:16];
          dq_out <= step[15:0];
          dq_oe_out <= 1'b1;
          ce_n_out <= 1'b0;
          oe_n_out <= 1'b1;
          if (timer == 20'h00000) begin
            we_n_out <= 1'b0;
            timer <= 20'(`SPL_WE_CYC - 1);
            state <= SPL_PULSE;
          end
        end
        SPL_PULSE: begin
          if (timer == 20'h00000) begin
            we_n_out <= 1'b1;
            timer <= 20'(`SPL_HOLD_CYC - 1);
            state <= SPL_HOLD;
          end
        end
        SPL_HOLD: begin
          if (timer == 20'h00000) begin
            ce_n_out <= 1'b1;
            dq_oe_out <= 1'b0;
            if (idx == `SPL_STEP_LAST) begin
              state <= SPL_DONE;
            end else if (idx == `SPL_STEP_ENTRY && cmd_q == SPL_CMD_PERSIST_READ) begin
              addr_out <= {sector_q, 16'h0000}; // Sector reads its bit
              timer <= 20'(`SPL_READ_CYC - 1);
              state <= SPL_READ;
            end else if (idx == `SPL_STEP_OP2) begin
              timer <= 20'(`SPL_BUSY_CYC - 1);
              waited <= 20'h00000;
              state <= SPL_BUSY;
            end else begin
              idx <= idx + 3'h1;
              timer <= 20'(`SPL_SETUP_CYC - 1);
              state <= SPL_SETUP;
            end
          end
        end
        SPL_READ: begin
          ce_n_out <= 1'b0;
          oe_n_out <= 1'b0;
          if (timer == 20'h00000 && dq_s3 == dq_s2) begin
            status_out <= dq_s3; // Zero protected, one unprotected
            ce_n_out <= 1'b1;
            oe_n_out <= 1'b1;
            idx <= `SPL_STEP_EXIT1;
            timer <= 20'(`SPL_SETUP_CYC - 1);
            state <= SPL_SETUP;
          end
        end
        SPL_BUSY: begin
          // Device runs preprogram and verify alone
          waited <= waited + 20'h00001;
          if (timer == 20'h00000 && (rdy || waited >= 20'(TIMEOUT_CYC))) begin
            err_q <= !rdy; // Timed out
            idx <= `SPL_STEP_EXIT1; // Always close with exit
            timer <= 20'(`SPL_SETUP_CYC - 1);
            state <= SPL_SETUP;
          end
        end
        SPL_RST: begin
          if (timer == 20'h00000) begin
            reset_n_out <= 1'b1;
            state <= SPL_DONE;
          end
        end
        SPL_DONE: begin
          done_out <= 1'b1;
          error_out <= err_q;
          busy_out <= 1'b0;
          state <= SPL_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks on the host side of the protocol
  a_pw_order: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (state == SPL_IDLE && cmd_valid_in && cmd_in == 3'h0 && !wdata_in[2] && !password_set_in)
      |-> ##2 (done_out && error_out))
    else $error("password select sent before password");
  a_sector_addr: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (state == SPL_PULSE && idx == 3'h4 && cmd_q == SPL_CMD_PERSIST_PROG)
      |-> (addr_out[25:16] == sector_q && dq_out == 16'h0000))
    else $error("sector address missing on program cycle");
  a_exit_follows: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (state == SPL_BUSY ##1 state != SPL_BUSY) |-> (state == SPL_SETUP && idx == 3'h5))
    else $error("no exit after operation");
  a_freeze_gate: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (state == SPL_IDLE && cmd_valid_in && cmd_in == 3'h5 && !config_final_in)
      |=> (state == SPL_DONE && $stable(ce_n_out)) ##1 error_out)
    else $error("freeze sent before configuration final");
  a_both_select: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (state == SPL_IDLE && cmd_valid_in && cmd_in == 3'h0 && wdata_in[2:1] == 2'b00)
      |-> ##1 state == SPL_DONE ##1 (done_out && error_out))
    else $error("both select bits sent together");
  a_frozen_guard: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (state == SPL_IDLE && cmd_valid_in && frozen && (cmd_in == 3'h1 || cmd_in == 3'h2))
      |=> state == SPL_DONE)
    else $error("persistent command sent while frozen");
  a_we_in_ce: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !we_n_out |-> (!ce_n_out && dq_oe_out && oe_n_out))
    else $error("write strobe outside chip select");

endmodule

// ### tb/spl_flash_model.sv
// Flash device model: protection bits, mode-select word and freeze latch
`timescale 1ns/1ps
module spl_flash_model #(
  parameter logic VOL_INIT = 1'b1
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_n_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic [25:0] addr_in,
  input wire logic [15:0] dq_in,
  input wire logic [7:0] busy_cyc_in,
  output logic ready_out,
  output logic [15:0] dq_out
);
  logic [1023:0] pers = '1;
  logic [1023:0] vol = '1;
  logic [15:0] modesel = 16'hFFFF;
  logic [15:0] last = 16'h0000;
  logic freeze = 1'b1;
  logic we_d = 1'b1;
  logic hang = 1'b0;
  logic [2:0] st = 3'h0;
  logic [7:0] mode = 8'h00;
  logic [7:0] cnt = 8'h00;
  logic [9:0] sec;
  logic pmode;
  assign sec = addr_in[25:16];
  assign pmode = (mode == 8'hC0);
  assign ready_out = (cnt == 8'h00) && !hang;
  // Persistent entry mode shows the sector bit; no array data; released bus flips
  assign dq_out = (!ce_n_in && !oe_n_in) ?
                  (pmode ? {15'h0, pers[sec]} : 16'hFFFF) : ~last;
  // Decoder, acting on the rising edge of the write strobe
  always @(posedge clk_in) begin
    we_d <= we_n_in;
    if (!ce_n_in && !oe_n_in) last <= dq_out;
    if (cnt != 8'h00) cnt <= cnt - 8'h01;
    if (!reset_n_in) begin
      freeze <= 1'b1;
      vol <= {1024{VOL_INIT}};
      st <= 3'h0;
      hang <= 1'b0;
      mode <= 8'h00;
    end else if (we_n_in && !we_d && !ce_n_in) begin
      case (st)
        3'h0: st <= (dq_in == 16'h00AA) ? 3'h1 : 3'h0;
        3'h1: st <= (dq_in == 16'h0055) ? 3'h2 : 3'h0;
        3'h2: begin
          mode <= dq_in[7:0];
          hang <= 1'b0;
          st <= 3'h3;
        end
        3'h3: st <= (dq_in == 16'h00A0) ? 3'h4 : (dq_in == 16'h0080) ? 3'h5 :
                    (dq_in == 16'h0090) ? 3'h6 : (dq_in == 16'h00AA) ? 3'h1 : 3'h3;
        3'h4: begin
          st <= 3'h3;
          cnt <= busy_cyc_in;
          if (mode == 8'h40 && dq_in[2:1] != 2'b00 && modesel[2:1] == 2'b11)
            modesel <= modesel & dq_in;
          if (pmode && !freeze) hang <= 1'b1;
          else if (pmode) pers[sec] <= 1'b0;
          // Protection judged from the bits as they stand now; protected writes dropped
          if (mode == 8'hE0 && pers[sec]) vol[sec] <= dq_in[0];
          if (mode == 8'h50 && !dq_in[0]) freeze <= 1'b0;
        end
        3'h5: begin
          st <= 3'h3;
          cnt <= busy_cyc_in;
          if (pmode && dq_in == 16'h0030 && !freeze) hang <= 1'b1;
          else if (pmode && dq_in == 16'h0030) pers <= '1;
        end
        default: begin
          st <= 3'h0;
          mode <= 8'h00;
          hang <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ### tb/tb_top.sv
// Self-checking bench of the sector protection host controller
`timescale 1ns/1ps
module tb_top;
  import spl_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cmd_valid_in = 1'b0;
  logic [2:0] cmd_in = 3'h0;
  logic [9:0] sector_in = 10'h000;
  logic [15:0] wdata_in = 16'h0000;
  logic password_set_in = 1'b0;
  logic config_final_in = 1'b0;
  logic [7:0] busy_cyc = 8'h20;
  logic ready, dq_oe, ce_n, we_n, oe_n, reset_n, busy, done_out, error_out;
  logic [25:0] addr;
  logic [15:0] dq_o, mdl_dq, status_out;
  wire logic [15:0] dq_bus = dq_oe ? dq_o : mdl_dq;
  int error_cnt = 0;
  int comparisons = 0;
  int done_cnt = 0;
  logic [17:0] exp_q[$];
  logic [17:0] e;
  logic [9:0] s;

  always #2 ref_clk_in = ~ref_clk_in;

  spl_host #(.TIMEOUT_CYC(200)) dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .sector_in(sector_in), .wdata_in(wdata_in),
    .password_set_in(password_set_in), .config_final_in(config_final_in), .ready_in(ready),
    .dq_in(dq_bus), .addr_out(addr), .dq_out(dq_o), .dq_oe_out(dq_oe), .ce_n_out(ce_n),
    .we_n_out(we_n), .oe_n_out(oe_n), .reset_n_out(reset_n), .busy_out(busy),
    .done_out(done_out), .error_out(error_out), .status_out(status_out));

  spl_flash_model mdl (.clk_in(ref_clk_in), .reset_n_in(reset_n), .ce_n_in(ce_n),
    .we_n_in(we_n), .oe_n_in(oe_n), .addr_in(addr), .dq_in(dq_bus), .busy_cyc_in(busy_cyc),
    .ready_out(ready), .dq_out(mdl_dq));

  task automatic close_out();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One order; expectation {check status, error, status}
  task automatic order(input logic [2:0] c, input logic [9:0] sa, input logic [15:0] w,
                       input logic [17:0] x);
    int d0;
    d0 = done_cnt;
    exp_q.push_back(x);
    @(posedge ref_clk_in);
    cmd_in <= c;
    sector_in <= sa;
    wdata_in <= w;
    cmd_valid_in <= 1'b1;
    @(posedge ref_clk_in);
    cmd_valid_in <= 1'b0;
    @(posedge ref_clk_in);
    chk({15'h0, busy}, 16'h0001);
    for (int n = 0; n < 4000 && done_cnt == d0; n++) @(posedge ref_clk_in);
    if (done_cnt == d0) begin
      error_cnt++;
      $display("[FAIL] t=%0t done_cnt=%h exp=%h", $time, done_cnt, d0 + 1);
      close_out();
    end
  endtask

  // Result watcher: oldest note against each completion
  always @(posedge ref_clk_in) begin
    if (done_out === 1'b1) begin
      e = exp_q.pop_front();
      done_cnt++;
      chk({15'h0, error_out}, {15'h0, e[16]});
      chk({15'h0, busy}, 16'h0000);
      if (e[17]) chk(status_out, e[15:0]);
    end
  end

  // Hang guard
  initial begin
    repeat (30000) @(posedge ref_clk_in);
    error_cnt++;
    close_out();
  end

  // Main sequence
  initial begin
    void'($urandom(11154));
    s = 10'($urandom_range(1022, 1));
    repeat (5) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    busy_cyc <= 8'($urandom_range(90, 25));
    order(3'h6, s, 16'h0000, 18'h20001);
    order(3'h1, s, 16'h0000, 18'h00000);
    order(3'h6, s, 16'h0000, 18'h20000);
    order(3'h6, s ^ 10'h001, 16'h0000, 18'h20001);
    order(3'h2, 10'h000, 16'h0000, 18'h00000);
    order(3'h6, s, 16'h0000, 18'h20001);
    order(3'h3, s, 16'h0000, 18'h00000);
    chk({15'h0, mdl.vol[s]}, 16'h0000);
    order(3'h4, s, 16'h0000, 18'h00000);
    chk({15'h0, mdl.vol[s]}, 16'h0001);
    order(3'h0, 10'h000, 16'hFFF9, 18'h10000);
    order(3'h0, 10'h000, 16'hFFFB, 18'h10000);
    order(3'h0, 10'h000, 16'hFFFD, 18'h00000);
    chk(mdl.modesel, 16'hFFFD);
    password_set_in <= 1'b1;
    order(3'h0, 10'h000, 16'hFFFB, 18'h10000);
    order(3'h5, 10'h000, 16'h0000, 18'h10000);
    config_final_in <= 1'b1;
    order(3'h5, 10'h000, 16'h0000, 18'h00000);
    chk({15'h0, mdl.freeze}, 16'h0000);
    order(3'h1, s, 16'h0000, 18'h10000);
    order(3'h7, 10'h000, 16'h0000, 18'h00000);
    chk({15'h0, mdl.freeze}, 16'h0001);
    order(3'h5, 10'h000, 16'h0000, 18'h00000);
    // Controller forgets the freeze; device still holds it
    rst_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    order(3'h1, s, 16'h0000, 18'h10000);
    order(3'h6, s, 16'h0000, 18'h20001);
    close_out();
  end
endmodule
